// ---- hw/rcsr_defines.vh ----
// constants of the residual current sensor readout
// assumes a 250 MHz core clock; included by bare name
`ifndef RCSR_DEFINES_VH
`define RCSR_DEFINES_VH

// ****************************************************************
// data format
// ****************************************************************
`define RCSR_WORD_W        16
`define RCSR_FRAME_BITS    40
`define RCSR_MID_CODE      16'h8000
`define RCSR_ERR_HIGH      10'h3FF
`define RCSR_HW_BIT        3
`define RCSR_ZERO_BIT      2
`define RCSR_RANGE_BIT     1
`define RCSR_CRIT_BIT      0
`define RCSR_CRC_INIT      8'hFF
`define RCSR_CRC_POLY      8'h07

// ****************************************************************
// timing
// ****************************************************************
`define RCSR_CLK_KHZ       250000
`define RCSR_CLK_MHZ       9'h0FA
`define RCSR_BS_MHZ        9'h030
`define RCSR_T_START_MS    100
`define RCSR_FAULT_KHZ     16
`define RCSR_START_CYC     (`RCSR_T_START_MS * `RCSR_CLK_KHZ)
`define RCSR_FAULT_HALF    (`RCSR_CLK_KHZ / (2 * `RCSR_FAULT_KHZ))

// ****************************************************************
// filter and buffer
// ****************************************************************
`define RCSR_LPF_SHIFT     12
`define RCSR_FIFO_DEPTH    8
`define RCSR_FIFO_AW       3

`endif

// ---- hw/rcsr_fifo.v ----
// sample buffer between the front end and the readout logic
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none

module rcsr_fifo
#(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output reg              o_ready,
  output reg  [WIDTH-1:0] o_data,
  output reg              o_valid,
  input  wire             i_ready
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             push;
  wire             load;
  wire [AW:0]      next_count;

  localparam [AW:0] FULL_COUNT = DEPTH;

  assign push       = i_valid & o_ready;
  assign load       = (count != {(AW+1){1'b0}}) & (~o_valid | i_ready);
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  always @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
    if (i_rst)
    begin
      wr_ptr  <= {AW{1'b0}};
      rd_ptr  <= {AW{1'b0}};
      count   <= {(AW+1){1'b0}};
      o_ready <= 1'b0;
      o_valid <= 1'b0;
      o_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      count   <= next_count;
      o_ready <= (next_count != FULL_COUNT);
      if (push)
      begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (load)
      begin
        o_data  <= mem[rd_ptr];
        o_valid <= 1'b1;
        rd_ptr  <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      else if (i_ready)
      begin
        o_valid <= 1'b0;
      end
    end
  end

endmodule // rcsr_fifo

`default_nettype wire

// ---- hw/rcsr_sdm.v ----
// first order sigma-delta modulator with a differential output pair
// assumes one clock, a bit-rate enable pulse and a synchronous reset
`timescale 1ns/100ps
`default_nettype none

module rcsr_sdm
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_en,
  input  wire [15:0] i_code,
  output reg         o_pos,
  output reg         o_neg
);

  reg  [15:0] acc;
  wire [16:0] sum;

  assign sum = {1'b0, acc} + {1'b0, i_code};

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      acc   <= 16'h0000;
      o_pos <= 1'b0;
      o_neg <= 1'b1;
    end
    else if (i_en)
    begin
      acc   <= sum[15:0];
      o_pos <= sum[16];
      o_neg <= ~sum[16];
    end
  end

endmodule // rcsr_sdm

`default_nettype wire

// ---- hw/rcsr_readout.v ----
// digital output side of the residual current sensor readout
// assumes a 250 MHz clock; pins arrive unsynchronised, front end
// samples and fault levels arrive on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "rcsr_defines.vh"

module rcsr_readout
#(
  parameter START_CYC  = `RCSR_START_CYC,
  parameter FAULT_HALF = `RCSR_FAULT_HALF
)
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_reset_n,
  input  wire        i_ss_n,
  input  wire        i_sclk,
  input  wire [15:0] i_sample,
  input  wire        i_sample_valid,
  output wire        o_sample_ready,
  input  wire        i_fault_hw,
  input  wire        i_fault_range,
  input  wire        i_fault_crit,
  output reg         o_miso,
  output reg         o_miso_oe,
  output wire        o_bs_pos,
  output wire        o_bs_neg,
  output reg         o_fault,
  output reg         o_running
);

  // ****************************************************************
  // spi states
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;

  // ****************************************************************
  // functions
  // ****************************************************************
  function [7:0] crc8_byte;
    input [7:0] crc_in;
    input [7:0] data_in;
    integer     i;
    reg   [7:0] c;
    begin
      c = crc_in ^ data_in;
      for (i = 0; i < 8; i = i + 1)
      begin
        c = c[7] ? ({c[6:0], 1'b0} ^ `RCSR_CRC_POLY) : {c[6:0], 1'b0};
      end
      crc8_byte = c;
    end
  endfunction

  function [7:0] crc8_words;
    input [15:0] w1;
    input [15:0] w2;
    reg   [7:0]  c;
    begin
      c = crc8_byte(`RCSR_CRC_INIT, w1[15:8]);
      c = crc8_byte(c, w1[7:0]);
      c = crc8_byte(c, w2[15:8]);
      crc8_words = crc8_byte(c, w2[7:0]);
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg rstn_m;
  reg rstn_q;
  reg ss_m;
  reg ss_q;
  reg ss_d;
  reg sclk_m;
  reg sclk_q;
  reg sclk_d;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rstn_m <= 1'b0;
      rstn_q <= 1'b0;
      ss_m   <= 1'b1;
      ss_q   <= 1'b1;
      ss_d   <= 1'b1;
      sclk_m <= 1'b0;
      sclk_q <= 1'b0;
      sclk_d <= 1'b0;
    end
    else
    begin
      rstn_m <= i_reset_n;
      rstn_q <= rstn_m;
      ss_m   <= i_ss_n;
      ss_q   <= ss_m;
      ss_d   <= ss_q;
      sclk_m <= i_sclk;
      sclk_q <= sclk_m;
      sclk_d <= sclk_q;
    end
  end

  wire dev_rst;
  wire ss_fall;
  wire ss_rise;
  wire sclk_rise;

  assign dev_rst   = i_rst | ~rstn_q;
  assign ss_fall   = ~ss_q & ss_d;
  assign ss_rise   = ss_q & ~ss_d;
  assign sclk_rise = sclk_q & ~sclk_d;

  // ****************************************************************
  // start-up interval
  // ****************************************************************
  reg [31:0] start_cnt;

  always @(posedge i_clk)
  begin
    if (dev_rst)
    begin
      start_cnt <= 32'h00000000;
      o_running <= 1'b0;
    end
    else if (start_cnt >= START_CYC - 1)
    begin
      o_running <= 1'b1;
    end
    else
    begin
      start_cnt <= start_cnt + 32'h00000001;
    end
  end

  // ****************************************************************
  // bitstream rate enable
  // ****************************************************************
  reg  [7:0] phase;
  reg        bs_en;
  wire [8:0] phase_sum;
  wire [8:0] phase_wrap;

  assign phase_sum  = {1'b0, phase} + `RCSR_BS_MHZ;
  assign phase_wrap = phase_sum - `RCSR_CLK_MHZ;

  always @(posedge i_clk)
  begin
    if (dev_rst)
    begin
      phase <= 8'h00;
      bs_en <= 1'b0;
    end
    else if (phase_sum >= `RCSR_CLK_MHZ)
    begin
      phase <= phase_wrap[7:0];
      bs_en <= 1'b1;
    end
    else
    begin
      phase <= phase_sum[7:0];
      bs_en <= 1'b0;
    end
  end

  // ****************************************************************
  // fault flags
  // ****************************************************************
  reg  hw_flag;
  reg  range_flag;
  reg  crit_flag;
  wire fault_any;

  // hardware fault survives the reset pin, only a power cycle clears it
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      hw_flag    <= 1'b0;
      range_flag <= 1'b0;
      crit_flag  <= 1'b0;
    end
    else
    begin
      hw_flag    <= hw_flag | i_fault_hw;
      range_flag <= i_fault_range;
      crit_flag  <= i_fault_crit;
    end
  end

  assign fault_any = hw_flag | range_flag | crit_flag;

  // ****************************************************************
  // sample buffer
  // ****************************************************************
  wire [15:0] buf_data;
  wire        buf_valid;
  wire        drain;

  // drained only at bit rate while running, so the buffer can fill
  assign drain = o_running & bs_en;

  rcsr_fifo
  #(
    .WIDTH (`RCSR_WORD_W),
    .DEPTH (`RCSR_FIFO_DEPTH),
    .AW    (`RCSR_FIFO_AW)
  )
  u_fifo
  (
    .i_clk   (i_clk),
    .i_rst   (dev_rst),
    .i_data  (i_sample),
    .i_valid (i_sample_valid),
    .o_ready (o_sample_ready),
    .o_data  (buf_data),
    .o_valid (buf_valid),
    .i_ready (drain)
  );

  // ****************************************************************
  // measurement words
  // ****************************************************************
  reg  [15:0] raw_word;
  reg  [31:0] lpf_acc;
  reg  [15:0] wide_word;
  wire [31:0] next_lpf;

  // narrow-band word as a first order iir of the same source
  assign next_lpf = lpf_acc - (lpf_acc >> `RCSR_LPF_SHIFT)
                  + ({buf_data, 16'h0000} >> `RCSR_LPF_SHIFT);

  always @(posedge i_clk)
  begin
    if (dev_rst)
    begin
      raw_word <= `RCSR_MID_CODE;
      lpf_acc  <= {`RCSR_MID_CODE, 16'h0000};
    end
    else if (drain & buf_valid)
    begin
      raw_word <= buf_data;
      lpf_acc  <= next_lpf;
    end
  end

  always @(posedge i_clk)
  begin
    if (dev_rst)
    begin
      wide_word <= `RCSR_MID_CODE;
    end
    else if (fault_any)
    begin
      wide_word <= {`RCSR_ERR_HIGH, 2'b00, hw_flag, 1'b0,
                    range_flag, crit_flag};
    end
    else
    begin
      wide_word <= raw_word;
    end
  end

  // ****************************************************************
  // sigma-delta output
  // ****************************************************************
  rcsr_sdm u_sdm
  (
    .i_clk  (i_clk),
    .i_rst  (dev_rst),
    .i_en   (bs_en),
    .i_code (wide_word),
    .o_pos  (o_bs_pos),
    .o_neg  (o_bs_neg)
  );

  // ****************************************************************
  // fault pin
  // ****************************************************************
  reg [15:0] fault_cnt;

  always @(posedge i_clk)
  begin
    if (dev_rst)
    begin
      fault_cnt <= 16'h0000;
      o_fault   <= 1'b0;
    end
    else if (o_running & ~fault_any)
    begin
      if (fault_cnt >= FAULT_HALF - 1)
      begin
        fault_cnt <= 16'h0000;
        o_fault   <= ~o_fault;
      end
      else
      begin
        fault_cnt <= fault_cnt + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // spi slave, mode 1, read only
  // ****************************************************************
  reg [2:0]  state;
  reg [39:0] frame;
  reg [5:0]  bit_cnt;

  always @(posedge i_clk)
  begin
    if (dev_rst)
    begin
      state     <= ST_IDLE;
      frame     <= 40'h0000000000;
      bit_cnt   <= 6'h00;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else if (ss_rise | (ss_q & (state != ST_IDLE)))
    begin
      state     <= ST_IDLE;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (ss_fall & o_running)
          begin
            frame     <= {wide_word, lpf_acc[31:16],
                          crc8_words(wide_word, lpf_acc[31:16])};
            bit_cnt   <= 6'h00;
            o_miso_oe <= 1'b1;
            state     <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (sclk_rise)
          begin
            o_miso  <= frame[39];
            frame   <= {frame[38:0], 1'b0};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == `RCSR_FRAME_BITS - 1)
            begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE:
        begin
          if (sclk_rise)
          begin
            o_miso <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // rcsr_readout

`default_nettype wire

// ---- verif/rcsr_readout_properties.sv ----
// pin checker of the sensor readout, bound into the readout
// assumes the shortened start and fault counts are handed on
`timescale 1ns/100ps
`default_nettype none

module rcsr_readout_properties
#(
  parameter START_CYC  = 50,
  parameter FAULT_HALF = 20
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_reset_n,
  input wire logic i_ss_n,
  input wire logic i_sclk,
  input wire logic i_fault_hw,
  input wire logic i_fault_range,
  input wire logic i_fault_crit,
  input wire logic o_sample_ready,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_bs_pos,
  input wire logic o_bs_neg,
  input wire logic o_fault,
  input wire logic o_running
);
  logic [15:0] up_cnt;
  logic [15:0] still_cnt;
  wire         healthy;
  assign healthy = o_running && !i_fault_hw && !i_fault_range && !i_fault_crit;

  // cycles since reset pin release, cycles since last fault pin edge
  always @(posedge i_clk)
  begin
    up_cnt <= (i_rst || !i_reset_n) ? 16'h0000 : up_cnt + 16'h0001;
    still_cnt <= (i_rst || !healthy || $changed(o_fault)) ? 16'h0000 : still_cnt + 16'h0001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence ss_open;
    (o_running && $fell(i_ss_n)) ##1 (!i_ss_n) [*5];
  endsequence
  sequence dev_held;
    (!i_reset_n) [*4];
  endsequence

  bs_pair_a: assert property (o_bs_neg == !o_bs_pos)
    else $error("bitstream pair not complementary");
  dev_held_a: assert property (
    dev_held |=> !o_running && !o_miso_oe && !o_sample_ready)
    else $error("outputs active while reset pin low");
  start_time_a: assert property (
    $rose(o_running) |-> up_cnt >= START_CYC && up_cnt <= START_CYC + 8)
    else $error("start-up interval wrong");
  idle_frame_a: assert property ($rose(o_miso_oe) |-> o_running)
    else $error("miso driven before start-up");
  oe_open_a: assert property (ss_open |-> o_miso_oe)
    else $error("miso not driven after select");
  ss_idle_a: assert property ((i_ss_n) [*6] |-> !o_miso_oe)
    else $error("miso driven while deselected");
  miso_settled_a: assert property (
    $fell(i_sclk) && o_miso_oe |-> $past(o_miso, 3) == o_miso)
    else $error("miso moved before trailing edge");
  fault_freeze_a: assert property (
    (i_fault_hw || i_fault_range || i_fault_crit) [*3] |=> $stable(o_fault))
    else $error("fault pin toggles during fault");
  fault_live_a: assert property (still_cnt <= FAULT_HALF + 4)
    else $error("fault pin stopped while healthy");
endmodule // rcsr_readout_properties

bind rcsr_readout rcsr_readout_properties
  #(.START_CYC(START_CYC), .FAULT_HALF(FAULT_HALF)) prop_u
(
  .i_clk(i_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_ss_n(i_ss_n), .i_sclk(i_sclk),
  .i_fault_hw(i_fault_hw), .i_fault_range(i_fault_range), .i_fault_crit(i_fault_crit),
  .o_sample_ready(o_sample_ready), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
  .o_bs_pos(o_bs_pos), .o_bs_neg(o_bs_neg), .o_fault(o_fault), .o_running(o_running)
);

`default_nettype wire

// ---- verif/rcsr_spi_host.sv ----
// host side of the serial link: select, serial clock, frame capture
// assumes the readout drives miso with an enable on the core clock
`timescale 1ns/100ps
`default_nettype none

module rcsr_spi_host
(
  input  wire logic i_clk,
  input  wire logic i_miso,
  input  wire logic i_oe,
  output var  logic o_ss_n,
  output var  logic o_sclk
);
  wire line;
  // released line shows the inverse of the current miso value
  assign line = i_oe ? i_miso : ~i_miso;

  initial
  begin
    o_ss_n = 1'b1;
    o_sclk = 1'b0;
  end

  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic select(input int k);
    o_ss_n = 1'b0;
    step(k);
    o_ss_n = 1'b1;
    step(60);
  endtask

  // half is the serial clock half period in core cycles
  task automatic read(input int half, input int bits, output logic [39:0] d);
    d = '0;
    o_ss_n = 1'b0;
    step(half);
    for (int k = 0; k < bits; k++)
    begin
      o_sclk = 1'b1;
      step(half);
      d = {d[38:0], line};
      o_sclk = 1'b0;
      step(half);
    end
    o_ss_n = 1'b1;
    step(60);
  endtask
endmodule // rcsr_spi_host

`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the sensor readout with a host model
// assumes the readout, its checker and the host model are compiled
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam SC = 50;
  localparam FH = 20;
  logic        i_clk = 0, i_rst = 1, i_reset_n = 1, i_sample_valid = 0;
  logic        i_fault_hw = 0, i_fault_range = 0, i_fault_crit = 0;
  logic [15:0] i_sample = 16'h8000, v, lo = 16'h8000, hi = 16'h8000;
  logic [39:0] fr;
  logic        p;
  wire         o_sample_ready, o_miso, o_miso_oe, o_bs_pos, o_bs_neg, o_fault, o_running;
  wire         ss_n, sclk;
  int          fails = 0, cmp_count = 0, seed = 34, n, m, i, ofs = 0;

  always #2 i_clk = ~i_clk;

  rcsr_readout #(.START_CYC(SC), .FAULT_HALF(FH)) dut_u
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_ss_n(ss_n), .i_sclk(sclk),
    .i_sample(i_sample), .i_sample_valid(i_sample_valid), .o_sample_ready(o_sample_ready),
    .i_fault_hw(i_fault_hw), .i_fault_range(i_fault_range), .i_fault_crit(i_fault_crit),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_bs_pos(o_bs_pos), .o_bs_neg(o_bs_neg),
    .o_fault(o_fault), .o_running(o_running)
  );
  rcsr_spi_host host_u
  (
    .i_clk(i_clk), .i_miso(o_miso), .i_oe(o_miso_oe), .o_ss_n(ss_n), .o_sclk(sclk)
  );

  // ****************************************************************
  // expectations and helpers
  // ****************************************************************
  function automatic logic [7:0] residue(input logic [39:0] f);
    logic [7:0] c;
    c = 8'hFF;
    for (int k = 4; k >= 0; k--)
    begin
      c = c ^ f[8*k+:8];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic feed(input logic [15:0] d, input int k);
    i_sample = d;
    i_sample_valid = 1'b1;
    lo = d < lo ? d : lo;
    hi = d > hi ? d : hi;
    step(k);
    i_sample_valid = 1'b0;
  endtask

  task automatic frame(input logic [15:0] wide);
    host_u.read(10, 40, fr);
    chk(16'(fr[39:24] - 16'h8000 - ofs), 16'(wide - 16'h8000));
    chk(residue(fr), 8'h00);
    chk((fr[39:30] == 10'h3FF && !fr[26]) || (fr[23:8] >= lo && fr[23:8] <= hi), 1);
  endtask

  task automatic wait_run;
    n = 0;
    while (o_running !== 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
  endtask

  task automatic toggles;
    m = 0;
    repeat (3 * FH)
    begin
      p = o_fault;
      step(1);
      m += (o_fault !== p);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    step(10);
    i_rst = 0;
    host_u.select(10);
    chk(o_miso_oe, 0);
    wait_run();
    chk(o_running, 1);
    i_reset_n = 0;
    step(10);
    chk({o_running, o_sample_ready, o_miso_oe}, 0);
    i_reset_n = 1;
    wait_run();
    chk(n >= SC && n <= SC + 8, 1);
    toggles();
    chk(m >= 2, 1);
    // start-up offset from averaged accuracy words, no current flowing
    for (i = 0; i < 4; i++)
    begin
      feed(16'h8000, 40);
      host_u.read(10, 40, fr);
      ofs += fr[23:8] - 16'h8000;
    end
    ofs = ofs / 4;
    chk(ofs, 0);
    // fill the buffer until it refuses, then let it drain
    i_sample = 16'($random(seed));
    feed(i_sample, 1);
    i_sample_valid = 1;
    n = 0;
    while (o_sample_ready === 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
    chk(o_sample_ready, 0);
    i_sample_valid = 0;
    step(80);
    chk(o_sample_ready, 1);
    for (i = 0; i < 5; i++)
    begin
      v = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? 16'h8000 : 16'($random(seed));
      feed(v, 100);
      frame(v);
    end
    host_u.read(10, 12, fr);
    frame(v);
    n = 0;
    m = 0;
    i_sample = 16'h8000;
    i_sample_valid = 1;
    step(200);
    repeat (2500)
    begin
      p = o_bs_pos;
      step(1);
      n += (o_bs_pos !== p);
      m += o_bs_pos;
    end
    i_sample_valid = 0;
    chk(n >= 470 && n <= 490, 1);
    chk(m >= 1150 && m <= 1350, 1);
    chk(o_bs_neg, !o_bs_pos);
    for (i = 1; i < 8; i++)
    begin
      {i_fault_hw, i_fault_range, i_fault_crit} = 3'(i);
      step(5);
      toggles();
      chk(m, 0);
      frame({10'h3FF, 2'b00, i[2], 1'b0, i[1], i[0]});
    end
    {i_fault_hw, i_fault_range, i_fault_crit, i_rst} = 4'h1;
    step(4);
    i_rst = 0;
    lo = 16'h8000;
    hi = 16'h8000;
    wait_run();
    feed(v, 100);
    frame(v);
    tally_and_finish();
  end

  initial
  begin
    step(80000);
    fails++;
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
